/* core/dmrb_bank.sv */
// Read-only register bank of the diagnostic monitor results.
`timescale 1ns/1ps
// Summary of operation
// - Upper eight result bits sit in bits 7..0 of the high register, reset zero.
// - Lowest four result bits sit in bits 7..4 of the low register, reset zero.
// - Output 2 positive at 0x66/0x67, identifier 1000b in low bits 3..0.
// - Output 2 negative at 0x68/0x69, identifier 1001b in low bits 3..0.
// - Temperature at 0x6A/0x6B, identifier 1010b in low bits 3..0.
// - Bias load at 0x6C/0x6D, identifier 1011b in low bits 3..0.
// - Analog supply at 0x6E/0x6F, identifier 1100b in low bits 3..0.
// - General analog input at 0x70/0x71, identifier 1101b in low bits 3..0.
// - Freeze bit set stops result updates; clear lets them update continuously.
module dmrb_bank (
   // Clock and reset
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_reset,
   // Monitor converter results
   input  wire dmrb_pkg::dmrb_sample_s i_sample,
   // Freeze control from the configuration register
   input  wire logic                  i_freeze_monitor_results,
   // Control port access
   input  wire dmrb_pkg::dmrb_access_s i_access,
   output logic                       o_hit,
   output logic [7:0]                 o_rdata
);

   logic [11:0] result   [dmrb_pkg::NUM_CH];
   logic [7:0]  rdata_r;
   logic [7:0]  rdata_nxt;

   // Fixed identifier of each channel slot, indexed by converter channel number.
   function automatic logic [3:0] chan_id(input logic [2:0] ch);
      unique case (ch)
         3'h0:    chan_id = dmrb_pkg::ID_OUTPUT2_POS;
         3'h1:    chan_id = dmrb_pkg::ID_OUTPUT2_NEG;
         3'h2:    chan_id = dmrb_pkg::ID_TEMPERATURE;
         3'h3:    chan_id = dmrb_pkg::ID_BIAS_LOAD;
         3'h4:    chan_id = dmrb_pkg::ID_ANALOG_SUPPLY;
         default: chan_id = dmrb_pkg::ID_GENERAL;
      endcase
   endfunction

   // Address decode shared by the read path and the hit flag.
   function automatic logic in_bank(input logic [7:0] a);
      in_bank = (a >= dmrb_pkg::BANK_FIRST) && (a <= dmrb_pkg::BANK_LAST);
   endfunction

   genvar g;
   generate
      for (g = 0; g < dmrb_pkg::NUM_CH; g++) begin : g_slot
         dmrb_result_slot u_slot (
            .i_ref_clk (i_ref_clk),
            .i_reset   (i_reset),
            .i_load    (i_sample.valid && (i_sample.channel == 3'(g))),
            .i_hold    (i_freeze_monitor_results),
            .i_value   (i_sample.value),
            .o_result  (result[g])
         );
      end
   endgenerate

   // Read mux; the pair index is the offset from the bank start divided by two.
   always_comb begin
      logic [7:0] off;
      logic [2:0] idx;
      off = 8'h00;
      idx = 3'h0;
      rdata_nxt = dmrb_pkg::UNMAPPED_DATA;
      if (in_bank(i_access.addr)) begin
         off = i_access.addr - dmrb_pkg::BANK_FIRST;
         idx = off[3:1];
         if (!off[0]) begin
            rdata_nxt = result[idx][dmrb_pkg::HIGH_MSB:dmrb_pkg::HIGH_LSB];
         end else begin
            rdata_nxt = {result[idx][dmrb_pkg::LOW_MSB:0], chan_id(idx)};
         end
      end
   end

   // Read data register; writes have no path to any stored state.
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         rdata_r <= dmrb_pkg::UNMAPPED_DATA;
      end else if (i_access.rd) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign o_rdata = rdata_r;
   assign o_hit   = in_bank(i_access.addr);

   property p_low_id_on_read;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_POS_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_OUTPUT2_POS);
   endproperty
   a_low_id_on_read: assert property (p_low_id_on_read) else $error("bad id 0x67");

   property p_id_neg;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_NEG_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_OUTPUT2_NEG);
   endproperty
   a_id_neg: assert property (p_id_neg) else $error("bad id 0x69");

   property p_id_temp;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::TEMPERATURE_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_TEMPERATURE);
   endproperty
   a_id_temp: assert property (p_id_temp) else $error("bad id 0x6B");

   property p_id_bias;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::BIAS_LOAD_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_BIAS_LOAD);
   endproperty
   a_id_bias: assert property (p_id_bias) else $error("bad id 0x6D");

   property p_id_supply;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::ANALOG_SUPPLY_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_ANALOG_SUPPLY);
   endproperty
   a_id_supply: assert property (p_id_supply) else $error("bad id 0x6F");

   property p_id_general;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::GENERAL_ANALOG_MONITOR_LOW)
         |=> (o_rdata[3:0] == dmrb_pkg::ID_GENERAL);
   endproperty
   a_id_general: assert property (p_id_general) else $error("bad id 0x71");

   property p_high_byte;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::TEMPERATURE_MONITOR_HIGH)
         |=> (o_rdata == $past(result[2][11:4]));
   endproperty
   a_high_byte: assert property (p_high_byte) else $error("high byte mismatch");

   property p_low_nibble;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_POS_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[0][3:0]));
   endproperty
   a_low_nibble: assert property (p_low_nibble) else $error("low nibble mismatch");

   property p_freeze;
      @(posedge i_ref_clk) disable iff (i_reset)
      i_freeze_monitor_results |=> $stable(result[0]) && $stable(result[1])
         && $stable(result[2]) && $stable(result[3])
         && $stable(result[4]) && $stable(result[5]);
   endproperty
   a_freeze: assert property (p_freeze) else $error("result changed while frozen");

   property p_update;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h1)
         |=> (result[1] == $past(i_sample.value));
   endproperty
   a_update: assert property (p_update) else $error("result not updated");

   property p_write_ignored;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.wr && !i_sample.valid) |=> $stable(result[0]) && $stable(result[1])
         && $stable(result[2]) && $stable(result[3])
         && $stable(result[4]) && $stable(result[5]);
   endproperty
   a_write_ignored: assert property (p_write_ignored) else $error("write changed result");

   property p_high_pos;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_POS_MONITOR_HIGH)
         |=> (o_rdata == $past(result[0][11:4]));
   endproperty
   a_high_pos: assert property (p_high_pos) else $error("bad high 0x66");

   property p_high_neg;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_NEG_MONITOR_HIGH)
         |=> (o_rdata == $past(result[1][11:4]));
   endproperty
   a_high_neg: assert property (p_high_neg) else $error("bad high 0x68");

   property p_high_bias;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::BIAS_LOAD_MONITOR_HIGH)
         |=> (o_rdata == $past(result[3][11:4]));
   endproperty
   a_high_bias: assert property (p_high_bias) else $error("bad high 0x6C");

   property p_high_supply;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::ANALOG_SUPPLY_MONITOR_HIGH)
         |=> (o_rdata == $past(result[4][11:4]));
   endproperty
   a_high_supply: assert property (p_high_supply) else $error("bad high 0x6E");

   property p_high_general;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::GENERAL_ANALOG_MONITOR_HIGH)
         |=> (o_rdata == $past(result[5][11:4]));
   endproperty
   a_high_general: assert property (p_high_general) else $error("bad high 0x70");

   property p_low_neg;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::OUTPUT2_NEG_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[1][3:0]));
   endproperty
   a_low_neg: assert property (p_low_neg) else $error("bad nibble 0x69");

   property p_low_temp;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::TEMPERATURE_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[2][3:0]));
   endproperty
   a_low_temp: assert property (p_low_temp) else $error("bad nibble 0x6B");

   property p_low_bias;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::BIAS_LOAD_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[3][3:0]));
   endproperty
   a_low_bias: assert property (p_low_bias) else $error("bad nibble 0x6D");

   property p_low_supply;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::ANALOG_SUPPLY_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[4][3:0]));
   endproperty
   a_low_supply: assert property (p_low_supply) else $error("bad nibble 0x6F");

   property p_low_general;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && i_access.addr == dmrb_pkg::GENERAL_ANALOG_MONITOR_LOW)
         |=> (o_rdata[7:4] == $past(result[5][3:0]));
   endproperty
   a_low_general: assert property (p_low_general) else $error("bad nibble 0x71");

   property p_update_pos;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h0)
         |=> (result[0] == $past(i_sample.value));
   endproperty
   a_update_pos: assert property (p_update_pos) else $error("stale ch0");

   property p_update_temp;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h2)
         |=> (result[2] == $past(i_sample.value));
   endproperty
   a_update_temp: assert property (p_update_temp) else $error("stale ch2");

   property p_update_bias;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h3)
         |=> (result[3] == $past(i_sample.value));
   endproperty
   a_update_bias: assert property (p_update_bias) else $error("stale ch3");

   property p_update_supply;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h4)
         |=> (result[4] == $past(i_sample.value));
   endproperty
   a_update_supply: assert property (p_update_supply) else $error("stale ch4");

   property p_update_general;
      @(posedge i_ref_clk) disable iff (i_reset)
      (!i_freeze_monitor_results && i_sample.valid && i_sample.channel == 3'h5)
         |=> (result[5] == $past(i_sample.value));
   endproperty
   a_update_general: assert property (p_update_general) else $error("stale ch5");

   property p_reset_clear;
      @(posedge i_ref_clk) disable iff (i_reset)
      $past(i_reset) |-> (o_rdata == dmrb_pkg::UNMAPPED_DATA)
         && (result[0] == dmrb_pkg::RESULT_RESET) && (result[1] == dmrb_pkg::RESULT_RESET)
         && (result[2] == dmrb_pkg::RESULT_RESET) && (result[3] == dmrb_pkg::RESULT_RESET)
         && (result[4] == dmrb_pkg::RESULT_RESET) && (result[5] == dmrb_pkg::RESULT_RESET);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("not cleared by reset");

   property p_unmapped_zero;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.rd && !o_hit)
         |=> (o_rdata == dmrb_pkg::UNMAPPED_DATA);
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped nonzero");

   property p_hit_inside;
      @(posedge i_ref_clk) disable iff (i_reset)
      ((i_access.addr == dmrb_pkg::BANK_FIRST) || (i_access.addr == dmrb_pkg::BANK_LAST))
         |-> o_hit;
   endproperty
   a_hit_inside: assert property (p_hit_inside) else $error("no hit at bank end");

   property p_hit_outside;
      @(posedge i_ref_clk) disable iff (i_reset)
      ((i_access.addr == dmrb_pkg::BANK_FIRST - 8'h01) || (i_access.addr == 8'h01 + dmrb_pkg::BANK_LAST))
         |-> !o_hit;
   endproperty
   a_hit_outside: assert property (p_hit_outside) else $error("hit outside bank");

   property p_write_rdata;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_access.wr && !i_access.rd)
         |=> $stable(o_rdata);
   endproperty
   a_write_rdata: assert property (p_write_rdata) else $error("write moved rdata");

   property p_spare_channel;
      @(posedge i_ref_clk) disable iff (i_reset)
      (i_sample.valid && i_sample.channel > 3'h5)
         |=> $stable(result[0]) && $stable(result[1]) && $stable(result[2])
         && $stable(result[3]) && $stable(result[4]) && $stable(result[5]);
   endproperty
   a_spare_channel: assert property (p_spare_channel) else $error("spare load");

endmodule

/* inc/dmrb_pkg.sv */
// Package with register map, channel identifiers and carrier types of the monitor readback bank.
package dmrb_pkg;

   localparam int unsigned NUM_CH     = 6;
   localparam int unsigned RESULT_W   = 12;
   localparam int unsigned ADDR_W     = 8;
   localparam int unsigned DATA_W     = 8;
   localparam int unsigned CH_W       = 3;

   // Byte addresses of the register pairs; the high part sits at the even address.
   localparam logic [7:0] OUTPUT2_POS_MONITOR_HIGH   = 8'h66;
   localparam logic [7:0] OUTPUT2_POS_MONITOR_LOW    = 8'h67;
   localparam logic [7:0] OUTPUT2_NEG_MONITOR_HIGH   = 8'h68;
   localparam logic [7:0] OUTPUT2_NEG_MONITOR_LOW    = 8'h69;
   localparam logic [7:0] TEMPERATURE_MONITOR_HIGH   = 8'h6A;
   localparam logic [7:0] TEMPERATURE_MONITOR_LOW    = 8'h6B;
   localparam logic [7:0] BIAS_LOAD_MONITOR_HIGH     = 8'h6C;
   localparam logic [7:0] BIAS_LOAD_MONITOR_LOW      = 8'h6D;
   localparam logic [7:0] ANALOG_SUPPLY_MONITOR_HIGH = 8'h6E;
   localparam logic [7:0] ANALOG_SUPPLY_MONITOR_LOW  = 8'h6F;
   localparam logic [7:0] GENERAL_ANALOG_MONITOR_HIGH = 8'h70;
   localparam logic [7:0] GENERAL_ANALOG_MONITOR_LOW  = 8'h71;

   localparam logic [7:0] BANK_FIRST = OUTPUT2_POS_MONITOR_HIGH;
   localparam logic [7:0] BANK_LAST  = GENERAL_ANALOG_MONITOR_LOW;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // Channel identifiers held in bits 3..0 of each low register.
   localparam logic [3:0] ID_OUTPUT2_POS   = 4'h8;
   localparam logic [3:0] ID_OUTPUT2_NEG   = 4'h9;
   localparam logic [3:0] ID_TEMPERATURE   = 4'hA;
   localparam logic [3:0] ID_BIAS_LOAD     = 4'hB;
   localparam logic [3:0] ID_ANALOG_SUPPLY = 4'hC;
   localparam logic [3:0] ID_GENERAL       = 4'hD;

   localparam logic [11:0] RESULT_RESET = 12'h000;

   // Result field positions.
   localparam int unsigned HIGH_MSB = 11;
   localparam int unsigned HIGH_LSB = 4;
   localparam int unsigned LOW_MSB  = 3;

   // One conversion result arriving from the monitor converter.
   typedef struct packed {
      logic              valid;
      logic [CH_W-1:0]   channel;
      logic [11:0]       value;
   } dmrb_sample_s;

   // One access on the device control port.
   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [7:0]        addr;
      logic [7:0]        wdata;
   } dmrb_access_s;

endpackage

/* core/dmrb_result_slot.sv */
// One monitored channel: stored 12-bit result with hold control.
`timescale 1ns/1ps
module dmrb_result_slot (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   // Update request
   input  wire logic        i_load,
   input  wire logic        i_hold,
   input  wire logic [11:0] i_value,
   // Stored result
   output logic      [11:0] o_result
);

   logic [11:0] result_r;

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         result_r <= dmrb_pkg::RESULT_RESET;
      end else if (i_load && !i_hold) begin
         result_r <= i_value;
      end
   end

   assign o_result = result_r;

endmodule

/* verif/tb_top.sv */
// Self-checking testbench of the monitor readback bank.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin failures++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module tb_top;
   logic                   i_ref_clk;
   logic                   i_reset;
   logic                   i_freeze_monitor_results;
   logic                   o_hit;
   logic [7:0]             o_rdata;
   dmrb_pkg::dmrb_sample_s i_sample;
   dmrb_pkg::dmrb_access_s i_access;
   int                     failures = 0;
   int                     total_checks = 0;
   logic [11:0]            v;
   logic [7:0]             ah;

   dmrb_bank uut (
      .i_ref_clk                (i_ref_clk),
      .i_reset                  (i_reset),
      .i_sample                 (i_sample),
      .i_freeze_monitor_results (i_freeze_monitor_results),
      .i_access                 (i_access),
      .o_hit                    (o_hit),
      .o_rdata                  (o_rdata)
   );

   initial begin
      i_ref_clk = 1'b0;
      forever #10 i_ref_clk = ~i_ref_clk;
   end

   task automatic stop_test;
      if (failures == 0 && total_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // One read strobe; the address decode is checked while the strobe is up.
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(posedge i_ref_clk);
      i_access <= {1'b1, 1'b0, a, 8'h00};
      #1 `CHK("hit", h, o_hit)
      @(posedge i_ref_clk);
      i_access <= '0;
      #1 `CHK("rdata", e, o_rdata)
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_access <= {1'b0, 1'b1, a, d};
      @(posedge i_ref_clk);
      i_access <= '0;
   endtask

   task automatic load(input logic [2:0] ch, input logic [11:0] val);
      @(posedge i_ref_clk);
      i_sample <= {1'b1, ch, val};
      @(posedge i_ref_clk);
      i_sample <= '0;
   endtask

   initial begin
      i_reset = 1'b1;
      i_sample = '0;
      i_access = '0;
      i_freeze_monitor_results = 1'b0;
      repeat (3) @(posedge i_ref_clk);
      i_reset <= 1'b0;
      // Reset contents of every pair, then two addresses just outside the bank.
      for (int ch = 0; ch < 6; ch++) begin
         ah = 8'h66 + 8'(2 * ch);
         rd(ah, 8'h00, 1'b1);
         rd(ah + 8'h01, {4'h0, 4'(8 + ch)}, 1'b1);
      end
      rd(8'h65, 8'h00, 1'b0);
      rd(8'h72, 8'h00, 1'b0);
      // A distinct result per channel lands in its own pair only.
      for (int ch = 0; ch < 6; ch++) begin
         v = 12'hA53 + 12'(ch) * 12'h111;
         ah = 8'h66 + 8'(2 * ch);
         load(3'(ch), v);
         rd(ah, v[11:4], 1'b1);
         rd(ah + 8'h01, {v[3:0], 4'(8 + ch)}, 1'b1);
      end
      // While frozen the temperature pair keeps its old result.
      @(posedge i_ref_clk);
      i_freeze_monitor_results <= 1'b1;
      load(3'd2, 12'h123);
      rd(8'h6A, 8'hC7, 1'b1);
      rd(8'h6B, 8'h5A, 1'b1);
      @(posedge i_ref_clk);
      i_freeze_monitor_results <= 1'b0;
      load(3'd2, 12'h123);
      rd(8'h6A, 8'h12, 1'b1);
      rd(8'h6B, 8'h3A, 1'b1);
      // Writes to the pair and outside the bank leave everything as it was.
      wr(8'h6A, 8'hFF);
      wr(8'h6B, 8'hF5);
      wr(8'h72, 8'hFF);
      rd(8'h6A, 8'h12, 1'b1);
      rd(8'h6B, 8'h3A, 1'b1);
      rd(8'h72, 8'h00, 1'b0);
      // A spare channel number loads nothing; a mid-run reset clears the temperature pair.
      load(3'd7, 12'h0FF);
      rd(8'h70, 8'hFA, 1'b1);
      @(posedge i_ref_clk);
      i_reset <= 1'b1;
      @(posedge i_ref_clk);
      i_reset <= 1'b0;
      rd(8'h6A, 8'h00, 1'b1);
      rd(8'h6B, 8'h0A, 1'b1);
      stop_test;
   end

   initial begin
      #40000;
      failures++;
      stop_test;
   end
endmodule
